// >>> hw/adls_pkg.sv
// adls_pkg: constants and types of the list sequencer
// assumes: 32-bit word bus, one register per aligned word
package adls_pkg;

  // ---------------------------------------------------------------
  // list geometry and result width
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_LAST = 6'h3f;
  localparam int unsigned RES_W = 12;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLOW = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_CIDX = 8'h10;
  localparam logic [7:0] OFS_RIDX = 8'h14;
  localparam logic [7:0] OFS_CSL0 = 8'h18;
  localparam logic [7:0] OFS_CSL1 = 8'h1c;
  localparam logic [7:0] OFS_RVL0 = 8'h20;
  localparam logic [7:0] OFS_RVL1 = 8'h24;
  localparam logic [7:0] OFS_IE = 8'h28;
  localparam logic [7:0] OFS_BGCMD = 8'h2c;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_MODE = 0;
  localparam int unsigned CTRL_RES = 1;
  localparam int unsigned CTRL_NVM = 3;
  localparam int unsigned CTRL_ERRIE = 4;
  localparam int unsigned CTRL_EOLIE = 5;
  localparam int unsigned FLOW_RESTART_REQUEST_BIT = 0;
  localparam int unsigned FLOW_LOAD_OK_BIT = 1;
  localparam int unsigned FLOW_TRIG = 2;
  localparam int unsigned FLOW_ABORT = 3;
  localparam int unsigned STAT_EOL = 0;
  localparam int unsigned STAT_IA = 1;
  localparam int unsigned STAT_BUSY = 2;
  localparam int unsigned STAT_ACSL = 3;
  localparam int unsigned STAT_ARVL = 4;
  localparam int unsigned STAT_ABG = 5;
  localparam int unsigned CMD_TYPE = 30;
  localparam int unsigned CMD_IRQ = 26;
  localparam int unsigned CMD_OPT = 22;

  // ---------------------------------------------------------------
  // resolution codes, memory windows, reset value
  // ---------------------------------------------------------------
  localparam logic [1:0] RES_8 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [31:0] RAM_LO = 32'h0000_1000;
  localparam logic [31:0] RAM_HI = 32'h0000_13ff;
  localparam logic [31:0] NVM_LO = 32'h0000_4000;
  localparam logic [31:0] NVM_HI = 32'h0000_ffff;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_NORMAL, CMD_EOS, CMD_EOL, CMD_RSVD
  } adls_cmd_e;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FIRST, ST_TRIG, ST_CONV, ST_STORE
  } adls_state_e;

endpackage : adls_pkg

// >>> hw/adls_bg_if.sv
// adls_bg_if: link between sequencer and background command store
// assumes: both ends on the same clock
`timescale 1ns/1ps
interface adls_bg_if;
  logic load;
  logic first;
  logic swap;
  logic [31:0] data;
  logic [31:0] active;
  logic [31:0] inactive;
  logic act_sel;
  modport ctl (output load, first, swap, data,
               input active, inactive, act_sel);
  modport store (input load, first, swap, data,
                 output active, inactive, act_sel);
endinterface : adls_bg_if

// >>> hw/adls_cmd_buf.sv
// adls_cmd_buf: two background command registers, one active
// assumes: load, first and swap come from the sequencer clock domain
`timescale 1ns/1ps
module adls_cmd_buf (
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // sequencer side
  adls_bg_if.store bg
);

  typedef struct packed {
    logic [31:0] reg0;
    logic [31:0] reg1;
    logic act;
  } adls_buf_s;

  adls_buf_s s;
  adls_buf_s next_s;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (bg.first) begin
      next_s.reg0 = bg.data;
      next_s.act = 1'b0;
    end else begin
      if (bg.load) begin
        if (s.act) begin
          next_s.reg0 = bg.data;
        end else begin
          next_s.reg1 = bg.data;
        end
      end
      if (bg.swap) begin
        next_s.act = ~s.act;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign bg.active = s.act ? s.reg1 : s.reg0;
  assign bg.inactive = s.act ? s.reg0 : s.reg1;
  assign bg.act_sel = s.act;

endmodule : adls_cmd_buf

// >>> hw/adls_sequencer.sv
// adls_sequencer: list based conversion sequencer with AHB-Lite regs
// assumes: one clock, memory port answers each request with an ack
`timescale 1ns/1ps
module adls_sequencer (
  // clock and control
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // list memory master
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [31:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  input wire logic MEM_ACK,
  input wire logic [31:0] MEM_RDATA,
  // analog converter
  output logic CONV_START,
  output logic [7:0] CONV_CHAN,
  output logic [1:0] CONV_RES,
  output logic [3:0] CONV_OPT,
  input wire logic CONV_DONE,
  input wire logic [11:0] CONV_DATA,
  // events
  input wire logic TRIG_IN,
  input wire logic RESTART_IN,
  // interrupts
  output logic CONV_IRQ,
  output logic EOL_IRQ,
  output logic ERR_IRQ
);

  typedef struct packed {
    adls_pkg::adls_state_e st;
    logic [5:0] cidx;
    logic [5:0] ridx;
    logic mode;
    logic [1:0] res;
    logic csl_nvm;
    logic err_ie;
    logic eol_ie;
    logic [15:1] ie;
    logic [15:1] conv_if;
    logic eol_if;
    logic ia_if;
    logic restart_request_bit;
    logic load_ok_bit;
    logic trig;
    logic abort;
    logic is_restart;
    logic act_csl;
    logic act_rvl;
    logic [31:0] csl0;
    logic [31:0] csl1;
    logic [31:0] rvl0;
    logic [31:0] rvl1;
    logic mem_req;
    logic mem_we;
    logic [31:0] mem_addr;
    logic [15:0] mem_wdata;
    logic conv_start;
    logic conv_got;
    logic [31:0] conv_cmd;
    logic [11:0] result;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } adls_seq_s;

  adls_seq_s s;
  adls_seq_s next_s;
  adls_bg_if bg ();

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] list_addr(logic [31:0] base,
                                            logic [5:0] idx);
    return base + {24'h0, idx, 2'b00};
  endfunction : list_addr

  function automatic logic in_win(logic [31:0] a, logic [31:0] lo,
                                  logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_win

  function automatic logic [11:0] scale(logic [11:0] d,
                                        logic [1:0] res);
    case (res)
      adls_pkg::RES_8: return {4'h0, d[11:4]};
      adls_pkg::RES_10: return {2'h0, d[11:2]};
      default: return d;
    endcase
  endfunction : scale

  // command read from the active list; a bad address stops all
  function automatic adls_seq_s issue_rd(adls_seq_s x);
    logic [31:0] a;
    logic ok;
    a = list_addr(x.act_csl ? x.csl1 : x.csl0, x.cidx);
    ok = in_win(a, adls_pkg::RAM_LO, adls_pkg::RAM_HI) ||
         (x.csl_nvm && in_win(a, adls_pkg::NVM_LO,
                              adls_pkg::NVM_HI));
    if (ok) begin
      x.mem_req = 1'b1;
      x.mem_we = 1'b0;
      x.mem_addr = a;
    end else begin
      x.ia_if = 1'b1;
      x.st = adls_pkg::ST_IDLE;
    end
    return x;
  endfunction : issue_rd

  // kick the converter and, unless the command is a list end, prefetch the following command
  function automatic adls_seq_s start_conv(adls_seq_s x,
                                           logic [31:0] cmd);
    x.conv_start = 1'b1;
    x.conv_cmd = cmd;
    x.conv_got = 1'b0;
    x.st = adls_pkg::ST_CONV;
    if (cmd[adls_pkg::CMD_TYPE +: 2] != 2'(adls_pkg::CMD_EOL)) begin
      if (x.cidx == adls_pkg::IDX_LAST) begin
        x.ia_if = 1'b1;
        x.st = adls_pkg::ST_IDLE;
      end else begin
        x.cidx = x.cidx + 6'h01;
        x = issue_rd(x);
      end
    end
    if (x.st == adls_pkg::ST_IDLE) begin
      x.conv_start = 1'b0;
    end
    return x;
  endfunction : start_conv

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [3:0] flow_set;
  logic [31:0] rd;
  logic [31:0] wa;
  logic [3:0] sel;
  adls_pkg::adls_cmd_e ty;

  always_comb begin
    next_s = s;
    flow_set = 4'h0;
    rd = adls_pkg::RST_WORD;
    wa = adls_pkg::RST_WORD;
    sel = s.conv_cmd[adls_pkg::CMD_IRQ +: 4];
    ty = adls_pkg::adls_cmd_e'(s.conv_cmd[adls_pkg::CMD_TYPE +: 2]);
    next_s.conv_start = 1'b0;
    bg.load = 1'b0;
    bg.first = 1'b0;
    bg.swap = 1'b0;
    bg.data = MEM_RDATA;

    // register writes, data phase
    if (s.wr_pend) begin
      case (s.wr_addr)
        adls_pkg::OFS_CTRL: begin
          next_s.mode = HWDATA[adls_pkg::CTRL_MODE];
          next_s.res = HWDATA[adls_pkg::CTRL_RES +: 2];
          next_s.csl_nvm = HWDATA[adls_pkg::CTRL_NVM];
          next_s.err_ie = HWDATA[adls_pkg::CTRL_ERRIE];
          next_s.eol_ie = HWDATA[adls_pkg::CTRL_EOLIE];
        end
        adls_pkg::OFS_FLOW: flow_set = HWDATA[3:0];
        adls_pkg::OFS_FLAGS: next_s.conv_if = s.conv_if & ~HWDATA[15:1];
        adls_pkg::OFS_STAT: begin
          next_s.eol_if = s.eol_if & ~HWDATA[adls_pkg::STAT_EOL];
          next_s.ia_if = s.ia_if & ~HWDATA[adls_pkg::STAT_IA];
        end
        adls_pkg::OFS_CSL0: next_s.csl0 = {HWDATA[31:2], 2'b00};
        adls_pkg::OFS_CSL1: next_s.csl1 = {HWDATA[31:2], 2'b00};
        adls_pkg::OFS_RVL0: next_s.rvl0 = {HWDATA[31:2], 2'b00};
        adls_pkg::OFS_RVL1: next_s.rvl1 = {HWDATA[31:2], 2'b00};
        adls_pkg::OFS_IE: next_s.ie = HWDATA[15:1];
        default: ;
      endcase
    end

    // address phase; read data is latched for the data phase
    next_s.wr_pend = 1'b0;
    if (HSEL && HTRANS[1] && HREADY) begin
      next_s.wr_pend = HWRITE;
      next_s.wr_addr = HADDR[7:0];
      case (HADDR[7:0])
        adls_pkg::OFS_CTRL: rd = {26'h0, s.eol_ie, s.err_ie,
                                  s.csl_nvm, s.res, s.mode};
        adls_pkg::OFS_FLOW: rd = {28'h0, s.abort, s.trig,
                                  s.load_ok_bit, s.restart_request_bit};
        adls_pkg::OFS_FLAGS: rd = {16'h0, s.conv_if, 1'b0};
        adls_pkg::OFS_STAT: rd = {26'h0, bg.act_sel, s.act_rvl,
                                  s.act_csl, s.st != adls_pkg::ST_IDLE,
                                  s.ia_if, s.eol_if};
        adls_pkg::OFS_CIDX: rd = {26'h0, s.cidx};
        adls_pkg::OFS_RIDX: rd = {26'h0, s.ridx};
        adls_pkg::OFS_CSL0: rd = s.csl0;
        adls_pkg::OFS_CSL1: rd = s.csl1;
        adls_pkg::OFS_RVL0: rd = s.rvl0;
        adls_pkg::OFS_RVL1: rd = s.rvl1;
        adls_pkg::OFS_IE: rd = {16'h0, s.ie, 1'b0};
        adls_pkg::OFS_BGCMD: rd = bg.active;
        default: rd = adls_pkg::RST_WORD;
      endcase
      next_s.rdata = HWRITE ? adls_pkg::RST_WORD : rd;
    end

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    if (s.restart_request_bit && !s.mem_req && s.st != adls_pkg::ST_FIRST) begin
      next_s.cidx = 6'h00;
      next_s.ridx = 6'h00;
      next_s.abort = 1'b0;
      next_s.trig = 1'b0;
      next_s.is_restart = 1'b1;
      next_s.st = adls_pkg::ST_FIRST;
      if (s.load_ok_bit) begin
        next_s.act_csl = ~s.act_csl;
        next_s.act_rvl = ~s.act_rvl;
      end
      next_s = issue_rd(next_s);
      next_s.restart_request_bit = next_s.st != adls_pkg::ST_IDLE;
      next_s.load_ok_bit = next_s.load_ok_bit & next_s.restart_request_bit;
    end else if (s.abort && !s.mem_req) begin
      next_s.abort = 1'b0;
      next_s.trig = 1'b0;
      next_s.st = adls_pkg::ST_IDLE;
    end else begin
      case (s.st)
        adls_pkg::ST_FIRST: begin
          if (MEM_ACK) begin
            next_s.mem_req = 1'b0;
            bg.first = 1'b1;
            if (s.is_restart) begin
              next_s.restart_request_bit = 1'b0;
              next_s.load_ok_bit = 1'b0;
            end
            next_s.st = adls_pkg::ST_TRIG;
          end
        end
        adls_pkg::ST_TRIG: begin
          if (s.trig) begin
            next_s.trig = 1'b0;
            next_s = start_conv(next_s, bg.active);
          end
        end
        adls_pkg::ST_CONV: begin
          if (s.mem_req && MEM_ACK) begin
            next_s.mem_req = 1'b0;
            bg.load = 1'b1;
          end
          if (CONV_DONE) begin
            next_s.result = scale(CONV_DATA, s.res);
            next_s.conv_got = 1'b1;
          end
          if (next_s.conv_got && !next_s.mem_req) begin
            wa = list_addr(s.act_rvl ? s.rvl1 : s.rvl0, s.ridx);
            if (in_win(wa, adls_pkg::RAM_LO, adls_pkg::RAM_HI)) begin
              next_s.mem_req = 1'b1;
              next_s.mem_we = 1'b1;
              next_s.mem_addr = wa;
              next_s.mem_wdata = {4'h0, next_s.result};
              next_s.st = adls_pkg::ST_STORE;
            end else begin
              next_s.ia_if = 1'b1;
              next_s.st = adls_pkg::ST_IDLE;
            end
          end
        end
        adls_pkg::ST_STORE: begin
          if (MEM_ACK) begin
            next_s.mem_req = 1'b0;
            next_s.mem_we = 1'b0;
            if (sel != 4'h0) begin
              next_s.conv_if[sel] = 1'b1;
            end
            if (s.ridx == adls_pkg::IDX_LAST &&
                ty != adls_pkg::CMD_EOL) begin
              next_s.ia_if = 1'b1;
              next_s.st = adls_pkg::ST_IDLE;
            end else begin
              next_s.ridx = s.ridx + 6'h01;
              case (ty)
                adls_pkg::CMD_EOL: begin
                  next_s.eol_if = 1'b1;
                  if (s.mode) begin
                    next_s.cidx = 6'h00;
                    next_s.ridx = 6'h00;
                    next_s.is_restart = 1'b0;
                    next_s.st = adls_pkg::ST_FIRST;
                    next_s = issue_rd(next_s);
                  end else begin
                    next_s.st = adls_pkg::ST_IDLE;
                  end
                end
                adls_pkg::CMD_EOS: begin
                  bg.swap = 1'b1;
                  next_s.st = adls_pkg::ST_TRIG;
                end
                default: begin
                  bg.swap = 1'b1;
                  next_s = start_conv(next_s, bg.inactive);
                end
              endcase
            end
          end
        end
        default: ;
      endcase
    end

    // requests set last so a same-cycle event is never lost
    next_s.restart_request_bit = next_s.restart_request_bit | flow_set[adls_pkg::FLOW_RESTART_REQUEST_BIT] |
                  RESTART_IN;
    next_s.load_ok_bit = next_s.load_ok_bit | flow_set[adls_pkg::FLOW_LOAD_OK_BIT];
    next_s.trig = next_s.trig | flow_set[adls_pkg::FLOW_TRIG] | TRIG_IN;
    next_s.abort = next_s.abort | flow_set[adls_pkg::FLOW_ABORT];
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s <= '0;
    end else if (CE) begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // background command store
  // ---------------------------------------------------------------
  adls_cmd_buf u_buf (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .bg(bg.store)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign HRDATA = s.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign MEM_REQ = s.mem_req;
  assign MEM_WE = s.mem_we;
  assign MEM_ADDR = s.mem_addr;
  assign MEM_WDATA = s.mem_wdata;
  assign CONV_START = s.conv_start;
  assign CONV_CHAN = s.conv_cmd[7:0];
  assign CONV_RES = s.res;
  assign CONV_OPT = s.conv_cmd[adls_pkg::CMD_OPT +: 4];
  assign CONV_IRQ = |(s.conv_if & s.ie);
  assign EOL_IRQ = s.eol_if & s.eol_ie;
  assign ERR_IRQ = s.ia_if & s.err_ie;

endmodule : adls_sequencer

// >>> test/adls_mem_model.sv
// adls_mem_model: list memory and converter beside the sequencer
// assumes: lists in ram 0x1000..0x13ff, one access at a time
`timescale 1ns/1ps
module adls_mem_model (
  // clock
  input wire logic CLK,
  // list memory port
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [15:0] MEM_WDATA,
  output logic MEM_ACK,
  output logic [31:0] MEM_RDATA,
  // converter
  input wire logic CONV_START,
  output logic CONV_DONE,
  output logic [11:0] CONV_DATA,
  // bench control
  input wire logic [3:0] dly,
  input wire logic [11:0] conv_val,
  output int wr_count,
  output int starts
);
  // ---------------------------------------------------------------
  // memory with variable answer delay
  // ---------------------------------------------------------------
  logic [31:0] ram [0:255];
  logic [31:0] last;
  logic [3:0] cnt;
  int cc;

  initial begin
    MEM_ACK = 1'b0;
    CONV_DONE = 1'b0;
    cnt = 4'h0;
    cc = -1;
    last = 32'h0;
    wr_count = 0;
    starts = 0;
  end

  // released data lines show the inverse, never a stale copy
  assign MEM_RDATA = MEM_ACK ? last : ~last;
  assign CONV_DATA = CONV_DONE ? conv_val : ~conv_val;

  always @(posedge CLK) begin
    MEM_ACK <= 1'b0;
    if (MEM_REQ && !MEM_ACK) begin
      if (cnt == dly) begin
        MEM_ACK <= 1'b1;
        cnt <= 4'h0;
        last <= ram[MEM_ADDR[9:2]];
        if (MEM_WE) begin
          ram[MEM_ADDR[9:2]] <= {16'h0, MEM_WDATA};
          wr_count <= wr_count + 1;
        end
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // converter: done a few cycles after start
  // ---------------------------------------------------------------
  always @(posedge CLK) begin
    CONV_DONE <= 1'b0;
    if (CONV_START) begin
      cc <= 0;
      starts <= starts + 1;
    end else if (cc == int'(dly) + 2) begin
      CONV_DONE <= 1'b1;
      cc <= -1;
    end else if (cc >= 0) begin
      cc <= cc + 1;
    end
  end
endmodule : adls_mem_model

// >>> test/adls_sequencer_checker.sv
// adls_sequencer_checker: port properties of the list sequencer
// assumes: bound to adls_sequencer, CE held high
`timescale 1ns/1ps
module adls_sequencer_checker (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // bus response
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // list memory
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [15:0] MEM_WDATA,
  input wire logic MEM_ACK,
  // converter and interrupts
  input wire logic CONV_START,
  input wire logic CONV_IRQ,
  input wire logic EOL_IRQ
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  wdata_width_a: assert property (
    MEM_REQ && MEM_WE |-> MEM_WDATA[15:12] == 4'h0)
    else $error("result wider than twelve bits");
  mem_window_a: assert property (
    MEM_REQ |-> (MEM_ADDR >= adls_pkg::RAM_LO
      && MEM_ADDR <= adls_pkg::RAM_HI) || (!MEM_WE
      && MEM_ADDR >= adls_pkg::NVM_LO && MEM_ADDR <= adls_pkg::NVM_HI))
    else $error("access outside memory issued");
  mem_hold_a: assert property (
    MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR)
      && $stable(MEM_WE) && $stable(MEM_WDATA))
    else $error("memory request changed before ack");
  mem_release_a: assert property (
    MEM_ACK |=> !MEM_REQ || $changed(MEM_WE))
    else $error("same memory request held after ack");
  conv_flag_a: assert property (
    $rose(CONV_IRQ) |-> $past(MEM_ACK) && $past(MEM_WE))
    else $error("conversion flag without finished store");
  eol_flag_a: assert property (
    $rose(EOL_IRQ) |-> $past(MEM_ACK) && $past(MEM_WE))
    else $error("list end flag without finished store");
  store_first_a: assert property (
    CONV_START |-> !(MEM_REQ && MEM_WE) ##1 !CONV_START)
    else $error("start during store or longer than a cycle");
  bus_okay_a: assert property (
    HREADYOUT && !HRESP)
    else $error("bus wait or error response");
endmodule : adls_sequencer_checker

bind adls_sequencer adls_sequencer_checker chk_i (.CLK, .RST, .HREADYOUT,
  .HRESP, .MEM_REQ, .MEM_WE, .MEM_ADDR, .MEM_WDATA, .MEM_ACK,
  .CONV_START, .CONV_IRQ, .EOL_IRQ);

// >>> test/adc_list_sequencer_test.sv
// adc_list_sequencer_test: register level tests of the list sequencer
// assumes: adls_mem_model serves list memory and converter
`timescale 1ns/1ps
module adc_list_sequencer_test;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic CE = 1'b1;
  logic HSEL = 1'b1;
  logic [31:0] HADDR = '0;
  logic [1:0] HTRANS = '0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = '0;
  logic TRIG_IN = 1'b0;
  logic RESTART_IN = 1'b0;
  logic HREADY, HREADYOUT, HRESP, MEM_REQ, MEM_WE, MEM_ACK;
  logic [31:0] HRDATA, MEM_ADDR, MEM_RDATA, rd;
  logic [15:0] MEM_WDATA;
  logic CONV_START, CONV_DONE, CONV_IRQ, EOL_IRQ, ERR_IRQ;
  logic [7:0] CONV_CHAN;
  logic [1:0] CONV_RES;
  logic [3:0] CONV_OPT;
  logic [11:0] CONV_DATA;
  logic [3:0] dly = 4'h0;
  logic [11:0] conv_val = 12'hc5a;
  logic [31:0] cmd [0:4];
  int wr_count, starts;
  int exp_wr = 0;
  int err_count = 0;
  int tests_run = 0;

  assign HREADY = HREADYOUT;
  always #5 CLK = ~CLK;

  adls_sequencer dut (.CLK, .RST, .CE, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .MEM_REQ,
    .MEM_WE, .MEM_ADDR, .MEM_WDATA, .MEM_ACK, .MEM_RDATA, .CONV_START,
    .CONV_CHAN, .CONV_RES, .CONV_OPT, .CONV_DONE, .CONV_DATA, .TRIG_IN,
    .RESTART_IN, .CONV_IRQ, .EOL_IRQ, .ERR_IRQ);
  adls_mem_model mem (.CLK, .MEM_REQ, .MEM_WE, .MEM_ADDR, .MEM_WDATA,
    .MEM_ACK, .MEM_RDATA, .CONV_START, .CONV_DONE, .CONV_DATA, .dly,
    .conv_val, .wr_count, .starts);

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge CLK);
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    do @(posedge CLK); while (HREADY !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADY !== 1'b1);
    rd = HRDATA;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk

  task automatic evt(input logic rs);
    @(posedge CLK);
    if (rs) RESTART_IN <= 1'b1;
    else TRIG_IN <= 1'b1;
    @(posedge CLK);
    RESTART_IN <= 1'b0;
    TRIG_IN <= 1'b0;
  endtask : evt

  task automatic wait_wr(input int n);
    exp_wr += n;
    for (int i = 0; i < 3000 && wr_count < exp_wr; i++) @(posedge CLK);
    repeat (20) @(posedge CLK);
    chk(wr_count, exp_wr);
  endtask : wait_wr

  task automatic restart(input logic [31:0] f, input logic rs);
    if (rs) evt(1'b1);
    else wr(adls_pkg::OFS_FLOW, f);
    for (int i = 0; i < 40; i++) begin
      bus(1'b0, adls_pkg::OFS_FLOW, 32'h0);
      if (rd[1:0] === 2'h0) break;
    end
    chk(rd, 32'h0);
    rchk(adls_pkg::OFS_CIDX, 32'h0);
    rchk(adls_pkg::OFS_RIDX, 32'h0);
  endtask : restart

  task automatic run(input logic [1:0] r);
    int s0;
    logic [11:0] e;
    s0 = starts;
    e = conv_val >> (r == 2'h0 ? 4 : r == 2'h1 ? 2 : 0);
    dly <= 4'(r) * 4'h3;
    for (int i = 64; i < 68; i++) mem.ram[i] = 32'h0;
    wr(adls_pkg::OFS_CTRL, {26'h0, 2'h3, 1'b0, r, 1'b0});
    wr(adls_pkg::OFS_FLAGS, 32'hfffe);
    wr(adls_pkg::OFS_STAT, 32'h3);
    restart(32'h1, r[0]);
    rchk(adls_pkg::OFS_BGCMD, cmd[0]);
    chk(starts, s0);
    evt(1'b0);
    wait_wr(2);
    chk(starts, s0 + 2);
    chk(mem.ram[64], {20'h0, e});
    chk(mem.ram[65], {20'h0, e});
    chk({20'h0, CONV_OPT, CONV_CHAN}, 32'h511);
    chk({30'h0, CONV_RES}, {30'h0, r});
    rchk(adls_pkg::OFS_FLAGS, 32'h6);
    rchk(adls_pkg::OFS_RIDX, 32'h2);
    rchk(adls_pkg::OFS_BGCMD, cmd[2]);
    wr(adls_pkg::OFS_FLOW, 32'h4);
    wait_wr(2);
    chk(mem.ram[67], {20'h0, e});
    rchk(adls_pkg::OFS_FLAGS, 32'h1e);
    chk({29'h0, CONV_IRQ, EOL_IRQ, ERR_IRQ}, 32'h6);
    evt(1'b0);
    repeat (20) @(posedge CLK);
    chk(starts, s0 + 4);
  endtask : run

  // ---------------------------------------------------------------
  // test sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    cmd[0] = {2'h0, 4'h1, 4'ha, 14'h0, 8'h05};
    cmd[1] = {2'h1, 4'h2, 4'h5, 14'h0, 8'h11};
    cmd[2] = {2'h0, 4'h3, 4'h3, 14'h0, 8'h22};
    cmd[3] = {2'h2, 4'h4, 4'hc, 14'h0, 8'h33};
    cmd[4] = {2'h2, 4'h5, 4'h9, 14'h0, 8'h44};
    for (int i = 0; i < 4; i++) mem.ram[i] = cmd[i];
    mem.ram[32] = cmd[4];
    mem.ram[97] = 32'hbeef;
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    rchk(adls_pkg::OFS_CIDX, 32'h0);
    wr(adls_pkg::OFS_CIDX, 32'h5);
    rchk(adls_pkg::OFS_CIDX, 32'h0);
    rchk(8'h40, 32'h0);
    wr(adls_pkg::OFS_CSL0, 32'h1000);
    wr(adls_pkg::OFS_RVL0, 32'h1100);
    wr(adls_pkg::OFS_CSL1, 32'h1080);
    wr(adls_pkg::OFS_RVL1, 32'h1180);
    wr(adls_pkg::OFS_IE, 32'hfffe);
    for (int r = 0; r < 4; r++) run(2'(r));
    wr(adls_pkg::OFS_CTRL, 32'h35);
    wr(adls_pkg::OFS_FLAGS, 32'hfffe);
    restart(32'h3, 1'b0);
    bus(1'b0, adls_pkg::OFS_STAT, 32'h0);
    chk(rd & 32'h18, 32'h18);
    rchk(adls_pkg::OFS_BGCMD, cmd[4]);
    evt(1'b0);
    wait_wr(1);
    rchk(adls_pkg::OFS_RIDX, 32'h0);
    rchk(adls_pkg::OFS_BGCMD, cmd[4]);
    rchk(adls_pkg::OFS_FLAGS, 32'h20);
    evt(1'b0);
    wait_wr(1);
    chk(mem.ram[97], 32'hbeef);
    chk(starts, 18);
    evt(1'b0);
    wr(adls_pkg::OFS_FLOW, 32'h8);
    repeat (40) @(posedge CLK);
    bus(1'b0, adls_pkg::OFS_STAT, 32'h0);
    chk(rd & 32'h4, 32'h0);
    restart(32'h1, 1'b0);
    rchk(adls_pkg::OFS_BGCMD, cmd[4]);
    wr(adls_pkg::OFS_CSL1, 32'h0800);
    wr(adls_pkg::OFS_FLOW, 32'h1);
    repeat (20) @(posedge CLK);
    bus(1'b0, adls_pkg::OFS_STAT, 32'h0);
    chk({rd[1], ERR_IRQ}, 2'h3);
    CE <= 1'b0;
    wr(adls_pkg::OFS_STAT, 32'h2);
    CE <= 1'b1;
    chk({31'h0, ERR_IRQ}, 32'h1);
    wr(adls_pkg::OFS_STAT, 32'h2);
    @(posedge CLK);
    chk({31'h0, ERR_IRQ}, 32'h0);
    wr(adls_pkg::OFS_CSL1, 32'h4000);
    wr(adls_pkg::OFS_CTRL, 32'h3d);
    restart(32'h1, 1'b0);
    rchk(adls_pkg::OFS_BGCMD, cmd[0]);
    complete_run();
  end

  initial begin
    repeat (30000) @(posedge CLK);
    err_count++;
    complete_run();
  end
endmodule : adc_list_sequencer_test
